// File: design/twm_pkg.sv
// Constants and carrier types for the three-wire motor input logic.
// Assumes digital inputs are already debounced and synchronous to sys_clk.
//
// Contract
// [RQ1] While a current-reference-select input is active, only the current-loop reference is used.
// [RQ2] The thermistor function may only be assigned to digital input 5; elsewhere it is rejected.
// [RQ3] Fault acknowledge always acts as a make contact and its inversion setting is ignored.
// [RQ4] A momentary ON pulse on the three-wire start input starts the motor.
// [RQ5] The three-wire stop input is a break contact; when it goes OFF the motor stops.
// [RQ6] Any state change on the three-wire direction input while running reverses the direction.
// [RQ7] Fault acknowledge asserted while running removes drive so the motor coasts to a stop.
// [RQ8] Run latches on start while stop is ON, clears when stop goes OFF; direction OFF is forward.
package twm_pkg;

  localparam int unsigned NUM_INPUTS = 5;
  localparam int unsigned FUNC_W = 5;
  localparam int unsigned PTC_INPUT_INDEX = 4;

  localparam logic [4:0] FUNC_NONE = 5'h00;
  localparam logic [4:0] FUNC_CUR_REF_SEL = 5'h10;
  localparam logic [4:0] FUNC_FAULT_ACK = 5'h12;
  localparam logic [4:0] FUNC_PTC = 5'h13;
  localparam logic [4:0] FUNC_START3 = 5'h14;
  localparam logic [4:0] FUNC_STOP3 = 5'h15;
  localparam logic [4:0] FUNC_DIR3 = 5'h16;

  localparam logic [1:0] REF_SRC_DEFAULT = 2'h0;
  localparam logic [1:0] REF_SRC_CURRENT = 2'h1;

  typedef struct packed {
    logic [FUNC_W-1:0] func;
    logic invert;
  } twm_input_cfg_t;

  typedef struct packed {
    logic run;
    logic reverse;
    logic coast;
  } twm_drive_t;

endpackage

// File: design/twm_input_map.sv
// Maps one terminal to its programmed function with polarity handling.
// Assumes the configuration is stable while the terminal is in use.
`timescale 1ns/100ps
module twm_input_map
  import twm_pkg::*;
#(
  parameter int unsigned INDEX = 0
)
(
  input wire logic pin,
  input twm_pkg::twm_input_cfg_t cfg,
  output logic [twm_pkg::FUNC_W-1:0] func,
  output logic level,
  output logic rejected
);

  always_comb
  begin
    func = cfg.func;
    rejected = 1'b0;
    if (cfg.func == FUNC_PTC && INDEX != PTC_INPUT_INDEX)
    begin
      func = FUNC_NONE; // [RQ2]
      rejected = 1'b1; // [RQ2]
    end
    // A forced make contact keeps a stuck inversion bit from latching a permanent reset.
    if (cfg.func == FUNC_FAULT_ACK)
      level = pin; // [RQ3]
    else
      level = pin ^ cfg.invert;
  end

endmodule

// File: design/twm_top.sv
// Top of the three-wire motor input logic: function routing and run latch.
// Assumes terminal levels are synchronous to sys_clk and configuration is static.
`timescale 1ns/100ps
module twm_top
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [twm_pkg::NUM_INPUTS-1:0] terminal_in,
  input twm_pkg::twm_input_cfg_t [twm_pkg::NUM_INPUTS-1:0] input_cfg,
  output logic motor_run,
  output logic motor_reverse,
  output logic motor_coast,
  output logic [1:0] reference_source,
  output logic ptc_active,
  output logic fault_ack,
  output logic [twm_pkg::NUM_INPUTS-1:0] cfg_rejected
);
  import twm_pkg::*;

  logic [FUNC_W-1:0] func_w [NUM_INPUTS];
  logic [NUM_INPUTS-1:0] level_w;
  logic [NUM_INPUTS-1:0] rej_w;

  ////////////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_map
      twm_input_map #(.INDEX(gi)) u_map
      (
        .pin(terminal_in[gi]),
        .cfg(input_cfg[gi]),
        .func(func_w[gi]),
        .level(level_w[gi]),
        .rejected(rej_w[gi])
      );
    end
  endgenerate

  function automatic logic any_func(input logic [FUNC_W-1:0] code,
                                    input logic [NUM_INPUTS-1:0] lv,
                                    input logic [FUNC_W-1:0] f [NUM_INPUTS]);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++)
      if (f[i] == code && lv[i])
        hit = 1'b1;
    return hit;
  endfunction

  function automatic logic has_func(input logic [FUNC_W-1:0] code,
                                    input logic [FUNC_W-1:0] f [NUM_INPUTS]);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++)
      if (f[i] == code)
        hit = 1'b1;
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic start_w;
  logic stop_ok_w;
  logic dir_w;
  logic ack_w;
  logic start_reg;
  logic run_next;

  always_comb
  begin
    start_w = any_func(FUNC_START3, level_w, func_w);
    // Without a stop terminal assigned, stop is taken as OFF so three-wire cannot run.
    stop_ok_w = any_func(FUNC_STOP3, level_w, func_w); // [RQ5]
    dir_w = any_func(FUNC_DIR3, level_w, func_w);
    ack_w = any_func(FUNC_FAULT_ACK, level_w, func_w);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    // Only start needs an edge history; direction is followed as a level.
    if (sys_rst)
      start_reg <= 1'b0;
    else
      start_reg <= start_w;
  end

  always_comb
  begin
    run_next = motor_run;
    if (start_w && !start_reg && stop_ok_w)
      run_next = 1'b1; // [RQ4] [RQ8]
    if (!stop_ok_w)
      run_next = 1'b0; // [RQ5] [RQ8]
    if (ack_w)
      run_next = 1'b0; // [RQ7]
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      motor_run <= 1'b0;
    else
      motor_run <= run_next;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      motor_reverse <= 1'b0;
    else
      motor_reverse <= dir_w; // [RQ6] [RQ8]
  end

  // Coast is held until the next start so the ramp logic never takes over mid-spin.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      motor_coast <= 1'b0;
    else if (ack_w && motor_run)
      motor_coast <= 1'b1; // [RQ7]
    else if (run_next)
      motor_coast <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      reference_source <= REF_SRC_DEFAULT;
    else
      reference_source <= any_func(FUNC_CUR_REF_SEL, level_w, func_w) ?
                          REF_SRC_CURRENT : REF_SRC_DEFAULT; // [RQ1]
  end

  // Only a validly placed thermistor function counts; rejected ones read as none.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ptc_active <= 1'b0;
    else
      ptc_active <= has_func(FUNC_PTC, func_w); // [RQ2]
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      fault_ack <= 1'b0;
    else
      fault_ack <= ack_w; // [RQ3]
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cfg_rejected <= '0;
    else
      cfg_rejected <= rej_w; // [RQ2]
  end

endmodule

// File: tb/twm_properties.sv
// Checker bound to the motor input top.
// Assumes inputs 1 to 5 carry start, stop, direction, ack and reference.
`timescale 1ns/100ps
module twm_properties
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [4:0] terminal_in,
  input twm_pkg::twm_input_cfg_t [4:0] input_cfg,
  input wire logic motor_run,
  input wire logic motor_reverse,
  input wire logic motor_coast,
  input wire logic [1:0] reference_source,
  input wire logic ptc_active,
  input wire logic fault_ack,
  input wire logic [4:0] cfg_rejected
);
  import twm_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire [4:0] tin = terminal_in;
  wire run = motor_run;
  sequence s_start;
    !tin[0] ##1 tin[0] && tin[1] && !tin[3];
  endsequence
  property p_start; s_start |=> run; endproperty
  a_start: assert property (p_start) else $error("start lost");
  property p_stop; !tin[1] |=> !run; endproperty
  a_stop: assert property (p_stop) else $error("stop lost");
  property p_dir; run && $changed(tin[2]) |=> $changed(motor_reverse); endproperty
  a_dir: assert property (p_dir) else $error("no reversal");
  property p_coast; run && tin[3] |=> !run && motor_coast; endproperty
  a_coast: assert property (p_coast) else $error("no coast");
  property p_hold; run && tin[1] && !tin[3] |=> run && motor_reverse == $past(tin[2]); endproperty
  a_hold: assert property (p_hold) else $error("run lost");
  property p_ack; 1'b1 |=> fault_ack == $past(tin[3]); endproperty
  a_ack: assert property (p_ack) else $error("ack polarity");
  property p_ref; input_cfg[4].func == FUNC_CUR_REF_SEL
    |=> reference_source == {1'b0, $past(tin[4])}; endproperty
  a_ref: assert property (p_ref) else $error("wrong reference");
  property p_ptc; 1'b1 |=> ptc_active == ($past(input_cfg[4].func) == FUNC_PTC)
    && cfg_rejected[0] == ($past(input_cfg[0].func) == FUNC_PTC); endproperty
  a_ptc: assert property (p_ptc) else $error("thermistor map");
endmodule
bind twm_top twm_properties u_props (.*);

// File: tb/twm_switches.sv
// Switch model driving the input terminals.
// Assumes the bench requests a start pulse by raising press for one cycle.
`timescale 1ns/100ps
module twm_switches
(
  input wire logic sys_clk,
  input wire logic press,
  input wire logic [3:0] hold,
  output logic [4:0] pins
);
  // Start is only pulsed, never held, so the device must latch run.
  always_ff @(posedge sys_clk)
    pins <= {hold, press};
endmodule

// File: tb/twm_top_bench.sv
// Bench for the motor input top: scripted and random switch steps.
// Assumes the switch model and the bound checker.
`timescale 1ns/100ps
module twm_top_bench;
  import twm_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, press = 1'b0;
  logic [3:0] hold = 4'h0;
  wire [4:0] pins;
  wire [11:0] got;
  twm_input_cfg_t [4:0] cfg;
  logic [11:0] q[$];
  int errors = 0, n_tests = 0, seed = 32'hc7de, r;
  twm_switches SW (.sys_clk(sys_clk), .press(press), .hold(hold), .pins(pins));
  twm_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .terminal_in(pins), .input_cfg(cfg),
    .motor_run(got[11]), .motor_reverse(got[10]), .motor_coast(got[9]), .fault_ack(got[8]),
    .reference_source(got[7:6]), .ptc_active(got[5]), .cfg_rejected(got[4:0]));
  initial
    forever #20 sys_clk = ~sys_clk;
  task automatic cmp(input logic [11:0] e, g);
    n_tests++;
    if (e !== g)
    begin
      errors++;
      $display("MISMATCH %0t %h %h", $time, e, g);
    end
  endtask
  task automatic step(input logic [4:0] s, input logic [11:0] e);
    press <= s[0];
    hold <= s[4:1];
    @(posedge sys_clk);
    press <= 1'b0;
    repeat (2) @(posedge sys_clk);
    q.push_back(e);
  endtask
  task automatic print_verdict;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
    forever
    begin
      @(negedge sys_clk);
      if (q.size() != 0)
        cmp(q.pop_front(), got);
    end
  initial
  begin
    cfg = {{FUNC_CUR_REF_SEL, 1'b0}, {FUNC_FAULT_ACK, 1'b1}, {FUNC_DIR3, 1'b0},
      {FUNC_STOP3, 1'b0}, {FUNC_START3, 1'b0}};
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    step(5'h01, 12'h000);
    step(5'h03, 12'h800);
    step(5'h16, 12'hc40);
    step(5'h14, 12'h440);
    step(5'h17, 12'hc40);
    step(5'h1e, 12'h740);
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      step({r[1], 1'b0, r[0], 2'h3}, {1'b1, r[0], 3'h0, r[1], 6'h00});
    end
    cfg[0].func <= FUNC_PTC;
    cfg[4].func <= FUNC_PTC;
    step({r[1], 1'b0, r[0], 2'h2}, {1'b1, r[0], 4'h0, 6'h21});
    repeat (2) @(negedge sys_clk);
    print_verdict();
  end
endmodule
